// >>> rtl/acc_pkg.sv
// package: offsets, field positions, reset values and timing counts of the calibration control block
package acc_pkg;
	// register word indices (printed offsets; every one is compared with paddr[9:2], so the byte address is four times it)
	localparam logic [7:0] acc_idx_acquisition_control = 8'h58;
	localparam logic [7:0] acc_idx_acquisition_status = 8'h5a;
	localparam logic [7:0] acc_idx_acc1 = 8'h5c;
	localparam logic [7:0] acc_idx_acc0 = 8'h5e;
	localparam logic [7:0] acc_idx_dec = 8'h60;
	localparam logic [7:0] acc_idx_compensation_control = 8'ha0;
	localparam logic [7:0] acc_idx_vos = 8'haa;
	localparam logic [7:0] acc_idx_ito = 8'hd0;
	localparam logic [7:0] acc_idx_itg = 8'hd1;
	// own registers
	localparam logic [7:0] acc_idx_tc_upper = 8'hb0;
	localparam logic [7:0] acc_idx_tc_lower = 8'hb1;
	localparam logic [7:0] acc_idx_temp = 8'hb2;
	localparam logic [7:0] acc_idx_cal_status = 8'hb3;
	localparam logic [7:0] acc_idx_pga_off0 = 8'hc0;
	localparam int acc_gain_count = 8;
	// fields
	localparam int acc_bit_autozero_request = 0;
	localparam int acc_bit_calreq_enable = 1;
	localparam int acc_bit_autozero_done = 0;
	localparam int acc_bit_calreq_flag = 1;
	localparam int acc_sr_flag_lsb = 8;
	// reset values
	localparam logic [7:0] acc_rst_byte = 8'h00;
	localparam logic [15:0] acc_rst_upper_limit = 16'h7fff;
	localparam logic [15:0] acc_rst_lower_limit = 16'h8000;
	// timing: auto-zero on the 512 kHz die link clock
	localparam int acc_autozero_link_cycles = 3352;
	localparam int acc_link_clock_khz = 512;
	localparam int acc_pclk_khz = 125000;
	localparam int acc_autozero_pclk_cycles = acc_autozero_link_cycles * (acc_pclk_khz / acc_link_clock_khz);
	localparam int acc_analog_option_one = 1;
	// auto-zero sequencer states
	typedef enum logic [1:0] {
		acc_az_idle = 2'b00,
		acc_az_run = 2'b01,
		acc_az_done = 2'b10
	} acc_az_e;
endpackage : acc_pkg

// >>> rtl/acc_az_if.sv
// interface: auto-zero handshake between register bank and sequencer
`timescale 1ns/100ps
`default_nettype none
interface acc_az_if;
	logic start;
	logic busy;
	logic finish;
	logic [10:0] offset_value;
	logic [2:0] offset_index;
	logic offset_write;
	modport bank (output start, input busy, input finish, input offset_value, input offset_index, input offset_write);
	modport seq (input start, output busy, output finish, output offset_value, output offset_index, output offset_write);
endinterface : acc_az_if
`default_nettype wire

// >>> rtl/acc_az_seq.sv
// auto-zero sequencer: times the run and produces per-gain offsets
`timescale 1ns/100ps
`default_nettype none
module acc_az_seq #(
	parameter int run_cycles = acc_pkg::acc_autozero_pclk_cycles
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [10:0] amp_offset_in,
	acc_az_if.seq az
);
	acc_pkg::acc_az_e state;
	acc_pkg::acc_az_e next_state;
	logic [31:0] count;
	logic [2:0] index;
	wire logic run_end = (count == 32'(run_cycles - 1));
	wire logic last_index = (index == 3'(acc_pkg::acc_gain_count - 1));
	// state decode
	always_comb begin
		case (state)
			acc_pkg::acc_az_idle: next_state = az.start ? acc_pkg::acc_az_run : acc_pkg::acc_az_idle;
			acc_pkg::acc_az_run: next_state = run_end ? acc_pkg::acc_az_done : acc_pkg::acc_az_run;
			acc_pkg::acc_az_done: next_state = last_index ? acc_pkg::acc_az_idle : acc_pkg::acc_az_done;
			default: next_state = acc_pkg::acc_az_idle;
		endcase
	end
	// run timer and offset write-back walk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= acc_pkg::acc_az_idle;
			count <= 32'h0;
			index <= 3'h0;
		end else begin
			state <= next_state;
			count <= (state == acc_pkg::acc_az_run) ? count + 32'h1 : 32'h0;
			index <= (state == acc_pkg::acc_az_done) ? index + 3'h1 : 3'h0;
		end
	end
	assign az.busy = (state != acc_pkg::acc_az_idle);
	assign az.offset_write = (state == acc_pkg::acc_az_done);
	assign az.offset_index = index;
	assign az.offset_value = amp_offset_in;
	assign az.finish = (state == acc_pkg::acc_az_done) && last_index;
endmodule : acc_az_seq
`default_nettype wire

// >>> rtl/acc_regs.sv
// acquisition calibration control register bank on apb
//
// How it works
// - done flag set after auto-zero interval
// - interval is 3352 link clock cycles
// - writing one clears done flag
// - per-gain offsets updated and readable
// - temperature outside limits raises calibration request
// - option one leaves diagnostic references empty
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module acc_regs #(
	parameter int autozero_cycles = acc_pkg::acc_autozero_pclk_cycles,
	parameter int analog_option = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] temp_result,
	input wire logic temp_valid,
	input wire logic [7:0] status_events,
	input wire logic [7:0] status_levels,
	input wire logic [10:0] amp_offset_in,
	input wire logic [15:0] diag_reference,
	output logic [7:0] acq_control,
	output logic [7:0] chain_upper,
	output logic [7:0] chain_lower,
	output logic [3:0] decimation,
	output logic [7:0] voltage_offset_trim,
	output logic [7:0] temp_offset_trim,
	output logic [7:0] temp_gain_trim,
	output logic autozero_request,
	output logic calib_request,
	output logic [15:0] diag_value
);
	acc_az_if az();
	logic [7:0] status_flags;
	logic autozero_done_flag;
	logic calreq_enable;
	logic calreq_flag;
	logic [15:0] calib_temp_upper_limit;
	logic [15:0] calib_temp_lower_limit;
	logic [15:0] internal_temperature;
	logic [10:0] per_gain_amp_offset [acc_pkg::acc_gain_count];
	// apb decode
	wire logic access = psel && penable;
	wire logic wr = access && pwrite;
	wire logic [7:0] idx = paddr[9:2];
	wire logic [7:0] wv = pwdata[7:0];
	wire logic [7:0] wm = pwdata[15:8];
	wire logic [7:0] wb1 = pwdata[15:8];
	wire logic wr_ctl = wr && idx == acc_pkg::acc_idx_acquisition_control;
	wire logic wr_sr = wr && idx == acc_pkg::acc_idx_acquisition_status;
	wire logic wr_acc1 = wr && idx == acc_pkg::acc_idx_acc1;
	wire logic wr_acc0 = wr && idx == acc_pkg::acc_idx_acc0;
	wire logic wr_dec = wr && idx == acc_pkg::acc_idx_dec;
	wire logic wr_comp = wr && idx == acc_pkg::acc_idx_compensation_control;
	wire logic wr_vos = wr && idx == acc_pkg::acc_idx_vos;
	wire logic wr_ito = wr && idx == acc_pkg::acc_idx_ito;
	wire logic wr_itg = wr && idx == acc_pkg::acc_idx_itg;
	wire logic wr_up = wr && idx == acc_pkg::acc_idx_tc_upper;
	wire logic wr_lo = wr && idx == acc_pkg::acc_idx_tc_lower;
	wire logic wr_cal = wr && idx == acc_pkg::acc_idx_cal_status;
	wire logic is_off = idx >= acc_pkg::acc_idx_pga_off0 &&
		idx < acc_pkg::acc_idx_pga_off0 + 8'(acc_pkg::acc_gain_count);
	wire logic [2:0] off_sel = 3'(idx - acc_pkg::acc_idx_pga_off0);
	wire logic mapped = idx == acc_pkg::acc_idx_acquisition_control || idx == acc_pkg::acc_idx_acquisition_status ||
		idx == acc_pkg::acc_idx_acc1 || idx == acc_pkg::acc_idx_acc0 || idx == acc_pkg::acc_idx_dec ||
		idx == acc_pkg::acc_idx_compensation_control || idx == acc_pkg::acc_idx_vos || idx == acc_pkg::acc_idx_ito ||
		idx == acc_pkg::acc_idx_itg || idx == acc_pkg::acc_idx_tc_upper ||
		idx == acc_pkg::acc_idx_tc_lower || idx == acc_pkg::acc_idx_temp ||
		idx == acc_pkg::acc_idx_cal_status || is_off;
	// masked write helper: value bit moves only where mask is one
	function automatic logic [7:0] acc_masked(input logic [7:0] old, input logic [7:0] val, input logic [7:0] msk);
		acc_masked = (old & ~msk) | (val & msk);
	endfunction : acc_masked
	// auto-zero start on a masked write of one
	wire logic az_bit_write = wr_comp && wm[acc_pkg::acc_bit_autozero_request];
	wire logic next_az_request = az_bit_write ? wv[acc_pkg::acc_bit_autozero_request] : autozero_request;
	assign az.start = az_bit_write && wv[acc_pkg::acc_bit_autozero_request] && !autozero_request;
	wire logic az_finish_evt = az.finish;
	// temperature window check
	wire logic out_of_range = temp_valid &&
		($signed(temp_result) > $signed(calib_temp_upper_limit) ||
		$signed(temp_result) < $signed(calib_temp_lower_limit));
	wire logic calreq_event = out_of_range && calreq_enable;
	// read mux
	logic [15:0] rdata;
	always_comb begin
		rdata = 16'h0;
		case (idx)
			acc_pkg::acc_idx_acquisition_control: rdata = {8'h0, acq_control};
			acc_pkg::acc_idx_acquisition_status: rdata = {status_flags, status_levels};
			acc_pkg::acc_idx_acc1: rdata = {8'h0, chain_upper};
			acc_pkg::acc_idx_acc0: rdata = {8'h0, chain_lower};
			acc_pkg::acc_idx_dec: rdata = {12'h0, decimation};
			acc_pkg::acc_idx_compensation_control: rdata = {14'h0, calreq_enable, autozero_request};
			acc_pkg::acc_idx_vos: rdata = {8'h0, voltage_offset_trim};
			acc_pkg::acc_idx_ito: rdata = {8'h0, temp_offset_trim};
			acc_pkg::acc_idx_itg: rdata = {8'h0, temp_gain_trim};
			acc_pkg::acc_idx_tc_upper: rdata = calib_temp_upper_limit;
			acc_pkg::acc_idx_tc_lower: rdata = calib_temp_lower_limit;
			acc_pkg::acc_idx_temp: rdata = internal_temperature;
			acc_pkg::acc_idx_cal_status: rdata = {14'h0, calreq_flag, autozero_done_flag};
			default: rdata = is_off ? {5'h0, per_gain_amp_offset[off_sel]} : 16'h0;
		endcase
	end
	// apb answer: zero wait, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? {16'h0, rdata} : 32'h0;
		end
	end
	// masked control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_control <= acc_pkg::acc_rst_byte;
			chain_upper <= acc_pkg::acc_rst_byte;
			chain_lower <= acc_pkg::acc_rst_byte;
		end else begin
			if (wr_ctl) acq_control <= acc_masked(acq_control, wv, wm);
			if (wr_acc1) chain_upper <= acc_masked(chain_upper, wv, wm);
			if (wr_acc0) chain_lower <= acc_masked(chain_lower, wv, wm);
		end
	end
	// plain trims, decimation and limits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decimation <= 4'h0;
			voltage_offset_trim <= acc_pkg::acc_rst_byte;
			temp_offset_trim <= acc_pkg::acc_rst_byte;
			temp_gain_trim <= acc_pkg::acc_rst_byte;
			calib_temp_upper_limit <= acc_pkg::acc_rst_upper_limit;
			calib_temp_lower_limit <= acc_pkg::acc_rst_lower_limit;
		end else begin
			if (wr_dec) decimation <= wv[3:0];
			if (wr_vos) voltage_offset_trim <= wv;
			if (wr_ito) temp_offset_trim <= wv;
			if (wr_itg) temp_gain_trim <= wv;
			if (wr_up) calib_temp_upper_limit <= pwdata[15:0];
			if (wr_lo) calib_temp_lower_limit <= pwdata[15:0];
		end
	end
	// status flags: events set, write one clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags <= acc_pkg::acc_rst_byte;
		end else begin
			status_flags <= (status_flags & ~(wr_sr ? wb1 : 8'h0)) | status_events;
		end
	end
	// auto-zero request, calibration enable and sticky flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			autozero_request <= 1'b0;
			calreq_enable <= 1'b0;
			autozero_done_flag <= 1'b0;
			calreq_flag <= 1'b0;
			calib_request <= 1'b0;
		end else begin
			autozero_request <= next_az_request;
			if (wr_comp && wm[acc_pkg::acc_bit_calreq_enable]) calreq_enable <= wv[acc_pkg::acc_bit_calreq_enable];
			autozero_done_flag <= az_finish_evt ||
				(autozero_done_flag && !(wr_cal && pwdata[acc_pkg::acc_bit_autozero_done]));
			calreq_flag <= calreq_event ||
				(calreq_flag && !(wr_cal && pwdata[acc_pkg::acc_bit_calreq_flag]));
			calib_request <= calreq_event ||
				(calreq_flag && !(wr_cal && pwdata[acc_pkg::acc_bit_calreq_flag]));
		end
	end
	// latest temperature result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) internal_temperature <= 16'h0;
		else if (temp_valid) internal_temperature <= temp_result;
	end
	// per-gain offset store, one entry per gain
	genvar g;
	generate
		for (g = 0; g < acc_pkg::acc_gain_count; g++) begin : gain_offsets
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) per_gain_amp_offset[g] <= 11'h0;
				else if (az.offset_write && az.offset_index == 3'(g)) per_gain_amp_offset[g] <= az.offset_value;
			end
		end
	endgenerate
	// diagnostic reference: blank on analog option one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) diag_value <= 16'hffff;
		else diag_value <= (analog_option == acc_pkg::acc_analog_option_one) ? 16'hffff : diag_reference;
	end
	// auto-zero timer
	acc_az_seq #(
		.run_cycles(autozero_cycles)
	) u_az_seq (
		.pclk(pclk),
		.presetn(presetn),
		.amp_offset_in(amp_offset_in),
		.az(az.seq)
	);
endmodule : acc_regs
`default_nettype wire

// >>> test/acc_regs_assertions.sv
// assertion checker watching the calibration control bank ports
`timescale 1ns/100ps
`default_nettype none
module acc_regs_assertions #(
	parameter int analog_option = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic temp_valid,
	input wire logic [7:0] acq_control,
	input wire logic [7:0] voltage_offset_trim,
	input wire logic autozero_request,
	input wire logic calib_request,
	input wire logic [15:0] diag_value
);
	// decoded write takes per register
	wire logic wr_take = psel & penable & pwrite & pready;
	wire logic wr_ctl = wr_take && paddr == {2'h0, acc_pkg::acc_idx_acquisition_control, 2'h0};
	wire logic wr_comp = wr_take && paddr == {2'h0, acc_pkg::acc_idx_compensation_control, 2'h0};
	wire logic wr_vos = wr_take && paddr == {2'h0, acc_pkg::acc_idx_vos, 2'h0};
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_phase: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_ready_prompt: assert property (psel && !penable |=> pready)
		else $error("no answer in access cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_mask_hold: assert property (wr_ctl && pwdata[15:8] == 8'h00 |=> $stable(acq_control))
		else $error("control changed without mask");
	a_mask_load: assert property (wr_ctl && pwdata[15:8] == 8'hff |=> acq_control == $past(pwdata[7:0]))
		else $error("masked control not loaded");
	a_az_start: assert property (wr_comp && pwdata[8] && pwdata[0] |=> autozero_request)
		else $error("auto-zero not started");
	a_az_keep: assert property (wr_comp && !pwdata[8] |=> $stable(autozero_request))
		else $error("auto-zero changed without mask");
	a_trim_load: assert property (wr_vos |=> voltage_offset_trim == $past(pwdata[7:0]))
		else $error("trim not loaded");
	a_diag_blank: assert property (analog_option == 1 |-> diag_value == 16'hffff)
		else $error("diagnostic value not blank");
	a_calreq_cause: assert property ($rose(calib_request) |-> $past(temp_valid) || $past(temp_valid, 2))
		else $error("calibration request without temperature");
endmodule : acc_regs_assertions
bind acc_regs acc_regs_assertions #(.analog_option(analog_option)) i_chk (.*);
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the calibration control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, temp_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] temp_result = 16'h0, diag_reference = 16'h1234;
	logic [7:0] status_events = 8'h00, status_levels = 8'h3c;
	logic [10:0] amp_offset_in = 11'h5a3;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, autozero_request, calib_request, rerr;
	logic [7:0] acq_control, chain_upper, chain_lower, voltage_offset_trim, temp_offset_trim, temp_gain_trim;
	logic [3:0] decimation;
	logic [15:0] diag_value;
	int err_count = 0, check_count = 0, cyc = 0, t0;
	acc_regs #(.autozero_cycles(20), .analog_option(1)) i_dut (.*);
	// clock
	always #4 pclk = ~pclk;
	// cycle count and hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		chk({31'h0, pready}, 32'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdat, exp);
	endtask : rd
	task automatic temp(input logic [15:0] t);
		temp_result <= t;
		temp_valid <= 1'b1;
		@(posedge pclk);
		temp_valid <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : temp
	// main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(acc_pkg::acc_idx_tc_upper, 32'h7fff);
		rd(acc_pkg::acc_idx_tc_lower, 32'h8000);
		wr(acc_pkg::acc_idx_acquisition_control, 32'h00ff);
		rd(acc_pkg::acc_idx_acquisition_control, 32'h0);
		wr(acc_pkg::acc_idx_acquisition_control, 32'hffa5);
		wr(acc_pkg::acc_idx_acquisition_control, 32'h0f5a);
		rd(acc_pkg::acc_idx_acquisition_control, 32'haa);
		chk({24'h0, acq_control}, 32'haa);
		for (int i = 0; i < 3; i++) begin
			wr(i == 0 ? acc_pkg::acc_idx_vos : acc_pkg::acc_idx_ito + i - 1, 32'h31 + i);
			rd(i == 0 ? acc_pkg::acc_idx_vos : acc_pkg::acc_idx_ito + i - 1, 32'h31 + i);
		end
		chk({24'h0, temp_gain_trim}, 32'h33);
		chk({24'h0, temp_offset_trim}, 32'h32);
		wr(acc_pkg::acc_idx_vos, 32'h44);
		rd(acc_pkg::acc_idx_vos, 32'h44);
		chk({24'h0, voltage_offset_trim}, 32'h44);
		wr(acc_pkg::acc_idx_dec, 32'h0f);
		rd(acc_pkg::acc_idx_dec, 32'h0f);
		chk({28'h0, decimation}, 32'hf);
		wr(acc_pkg::acc_idx_acc1, 32'h1010);
		rd(acc_pkg::acc_idx_acc1, 32'h10);
		chk({24'h0, chain_upper}, 32'h10);
		wr(acc_pkg::acc_idx_acc0, 32'h0f0f);
		chk({24'h0, chain_lower}, 32'h0f);
		apb(1'b0, 8'h01, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		// auto-zero run, poll done flag
		wr(acc_pkg::acc_idx_compensation_control, 32'h0101);
		t0 = cyc;
		chk({31'h0, autozero_request}, 32'h1);
		do apb(1'b0, acc_pkg::acc_idx_cal_status, 32'h0);
		while (rdat[0] !== 1'b1 && cyc - t0 < 200);
		chk({31'h0, cyc - t0 >= 19 && cyc - t0 <= 40}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			rd(acc_pkg::acc_idx_pga_off0 + i, 32'h5a3);
		end
		wr(acc_pkg::acc_idx_compensation_control, 32'h0100);
		chk({31'h0, autozero_request}, 32'h0);
		wr(acc_pkg::acc_idx_cal_status, 32'h1);
		rd(acc_pkg::acc_idx_cal_status, 32'h0);
		// calibration range exit
		wr(acc_pkg::acc_idx_tc_upper, 32'h0100);
		wr(acc_pkg::acc_idx_tc_lower, 32'hff00);
		wr(acc_pkg::acc_idx_compensation_control, 32'h0202);
		temp(16'h0050);
		chk({31'h0, calib_request}, 32'h0);
		rd(acc_pkg::acc_idx_temp, 32'h0050);
		temp(16'hfe00);
		chk({31'h0, calib_request}, 32'h1);
		rd(acc_pkg::acc_idx_cal_status, 32'h2);
		wr(acc_pkg::acc_idx_tc_upper, 32'h0300);
		wr(acc_pkg::acc_idx_tc_lower, 32'hfd00);
		rd(acc_pkg::acc_idx_tc_upper, 32'h0300);
		rd(acc_pkg::acc_idx_tc_lower, 32'hfd00);
		wr(acc_pkg::acc_idx_cal_status, 32'h2);
		rd(acc_pkg::acc_idx_cal_status, 32'h0);
		temp(16'hfe00);
		chk({31'h0, calib_request}, 32'h0);
		// status flags
		status_events <= 8'h81;
		@(posedge pclk);
		status_events <= 8'h00;
		rd(acc_pkg::acc_idx_acquisition_status, 32'h813c);
		wr(acc_pkg::acc_idx_acquisition_status, 32'h0100);
		rd(acc_pkg::acc_idx_acquisition_status, 32'h803c);
		wr(acc_pkg::acc_idx_acquisition_status, 32'h0000);
		rd(acc_pkg::acc_idx_acquisition_status, 32'h803c);
		chk({16'h0, diag_value}, 32'hffff);
		final_report();
	end
endmodule : testbench
`default_nettype wire
